// ==== common/cfbx_pkg.sv ====
package cfbx_pkg;

  // Instruction word layout.
  localparam int          CFBX_WORD_W     = 16;
  localparam int          CFBX_PC_W       = 21;
  localparam int          CFBX_OPC_MSB    = 15;
  localparam int          CFBX_OPC_LSB    = 8;
  localparam int          CFBX_OFS_MSB    = 7;
  localparam int          CFBX_OFS_LSB    = 0;
  localparam logic [7:0]  CFBX_OPC_OVF    = 8'he4;
  localparam logic [7:0]  CFBX_OPC_ZERO   = 8'he0;

  // Phase and reset values.
  localparam logic [1:0]  CFBX_PHASE_RST  = 2'h0;
  localparam logic [1:0]  CFBX_PHASE_LAST = 2'h3;
  localparam logic [20:0] CFBX_PC_RST     = 21'h000000;

  // Sequencer states.
  typedef enum logic [1:0] {
    CFBX_ST_EXEC  = 2'b00,
    CFBX_ST_FLUSH = 2'b01
  } cfbx_state_type;

  // Instruction handed over by the fetch stage.
  typedef struct packed {
    logic        valid;
    logic [15:0] word;
  } cfbx_instr_type;

  // Status flags seen by the branch logic.
  typedef struct packed {
    logic ovf;
    logic zero;
  } cfbx_flags_type;

  // Program counter update toward the core.
  typedef struct packed {
    logic        load;
    logic [20:0] target;
  } cfbx_pcwr_type;

endpackage : cfbx_pkg

// ==== src/cfbx_phase_gen.sv ====
`timescale 1ns/1ps
`default_nettype none

module cfbx_phase_gen (
  // Clock and reset.
  input  wire logic                 core_clk,
  input  wire logic                 rstn,
  // Phase output.
  output var  logic [1:0]           phase_ff,
  output var  logic                 cycle_end_ff
);
  import cfbx_pkg::*;

  logic [1:0] nxt_phase;
  logic       nxt_cycle_end;

  // Four phases per instruction cycle; cycle_end marks the last phase.
  always_comb begin
    nxt_phase     = phase_ff + 2'h1;
    nxt_cycle_end = (nxt_phase == CFBX_PHASE_LAST);
  end

  // Phase registers.
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      phase_ff     <= CFBX_PHASE_RST;
      cycle_end_ff <= 1'b0;
    end else begin
      phase_ff     <= nxt_phase;
      cycle_end_ff <= nxt_cycle_end;
    end
  end

endmodule : cfbx_phase_gen

`default_nettype wire

// ==== src/cfbx_branch_exec.sv ====
// Function
// - Upper byte 1110 0100 is branch_on_overflow; taken only when overflow flag is one.
// - Low byte is a signed offset -128..127, doubled and added to PC.
// - PC already holds address plus 2, so target is address plus 2 plus 2n.
// - One word; one cycle when not taken, two cycles when taken.
`timescale 1ns/1ps
`default_nettype none

module cfbx_branch_exec #(
  // Program counter width; the carriers in the package are built for this value.
  parameter int PC_W  = cfbx_pkg::CFBX_PC_W,
  // Width of the signed offset literal in the low byte of the word.
  parameter int OFS_W = cfbx_pkg::CFBX_OFS_MSB - cfbx_pkg::CFBX_OFS_LSB + 1
) (
  // Clock and reset.
  input  wire logic                      core_clk,
  input  wire logic                      rstn,
  // Decoded instruction from fetch, with the incremented program counter.
  input  wire cfbx_pkg::cfbx_instr_type  instr,
  input  wire logic [20:0]               pc_now,
  // Status flags.
  input  wire cfbx_pkg::cfbx_flags_type  flags,
  // Program counter write.
  output var  cfbx_pkg::cfbx_pcwr_type   pcwr_ff,
  // Pipeline control.
  output var  logic                      flush_ff,
  output var  logic                      instr_done_ff,
  output var  logic                      is_branch_ff
);
  import cfbx_pkg::*;

  logic [1:0]     phase;
  logic           cycle_end;
  cfbx_state_type state_ff;
  cfbx_state_type nxt_state;
  cfbx_pcwr_type  nxt_pcwr;
  logic           nxt_flush;
  logic           nxt_done;
  logic           nxt_is_branch;
  logic [7:0]     opc;
  logic [7:0]     ofs;
  logic           hit_ovf;
  logic           hit_zero;
  logic           taken;
  logic [20:0]    disp;

  // Per-kind decode: entry 0 is the overflow branch, entry 1 the zero branch.
  localparam int              N_KIND   = 2;
  localparam logic [15:0]     KIND_OPC = {CFBX_OPC_ZERO, CFBX_OPC_OVF};
  logic [N_KIND-1:0]          kind_flag;
  logic [N_KIND-1:0]          kind_hit;
  logic [N_KIND-1:0]          kind_take;

  // How one instruction cycle runs through this block.
  //
  // The phase source counts four core clocks per instruction cycle and raises
  // cycle_end during the last of them. Everything this block decides is
  // decided on the clock edge that closes that last phase. At that edge the
  // fetch stage must still be presenting the word, the incremented program
  // counter and the flags; nothing earlier in the cycle is looked at.
  //
  // A word that is neither branch form leaves the load pulse, flush_ff, instr_done_ff
  // and is_branch_ff low. The fetch stage owns those instructions and this block stays out of the way.
  //
  // A branch whose flag is clear produces, for one clock after that edge,
  // is_branch_ff and instr_done_ff together. The program counter is left as
  // the fetch stage already advanced it, so the next word simply follows.
  //
  // A branch whose flag is set produces, for one clock after that edge, the
  // load pulse with the new target together with is_branch_ff, and raises
  // flush_ff. The sequencer then spends one whole further instruction cycle
  // in the flush state. During it flush_ff stays high so that the fetch stage
  // drops the word it had already fetched from the old address; any word that
  // is presented meanwhile is ignored here too. When that cycle closes,
  // flush_ff falls and instr_done_ff pulses for one clock.
  //
  // Hazards and limits a user of this block should know:
  // - The flags are taken as they stand at the closing edge. A flag that the
  //   previous instruction writes late must already be settled by then.
  // - The target wraps modulo the program counter width, so a branch near
  //   either end of program memory lands at the other end without warning.
  // - The target register keeps its last value between loads; only the load
  //   pulse says that it is meaningful.
  // - A reset in the middle of the flush cycle abandons the branch; the
  //   phase count restarts from zero with the reset.

  // Elaboration checks: the struct carriers and the doubling network are
  // sized for exactly these values, so refuse anything else.
  if (PC_W != CFBX_PC_W) begin : g_bad_pc_w
    $error("cfbx_branch_exec: PC_W must equal the program counter carrier width");
  end
  if (OFS_W != 8) begin : g_bad_ofs_w
    $error("cfbx_branch_exec: OFS_W must equal the offset field width of the word");
  end
  if (OFS_W + 1 > PC_W) begin : g_bad_mix
    $error("cfbx_branch_exec: the doubled offset must fit in the program counter");
  end

  // Instruction cycle phase source.
  cfbx_phase_gen u_phase (
    .core_clk     (core_clk),
    .rstn         (rstn),
    .phase_ff     (phase),
    .cycle_end_ff (cycle_end)
  );

  // Flag that each branch kind tests, in the order of the kind table.
  assign kind_flag = {flags.zero, flags.ovf};

  // One opcode match and one flag test per branch kind.
  for (genvar gk = 0; gk < N_KIND; gk++) begin : g_kind
    assign kind_hit[gk]  = instr.valid && (opc == KIND_OPC[gk*8 +: 8]);
    assign kind_take[gk] = kind_hit[gk] && kind_flag[gk];
  end

  // Doubled signed offset: bit 0 is zero, the literal sits one place up,
  // and every bit above it repeats the literal's sign bit.
  assign disp[0] = 1'b0;
  for (genvar gi = 1; gi < PC_W; gi++) begin : g_disp
    if (gi <= OFS_W) begin : g_lit
      assign disp[gi] = ofs[gi-1];
    end else begin : g_sign
      assign disp[gi] = ofs[OFS_W-1];
    end
  end

  // Split the word into opcode and offset and gather the per-kind results.
  always_comb begin
    opc      = instr.word[CFBX_OPC_MSB:CFBX_OPC_LSB];
    ofs      = instr.word[CFBX_OFS_MSB:CFBX_OFS_LSB];
    hit_ovf  = kind_hit[0];
    hit_zero = kind_hit[1];
    taken    = |kind_take;
  end

  // Next state: execute cycle, then one flush cycle after a taken branch.
  always_comb begin
    nxt_state     = state_ff;
    nxt_pcwr.load = 1'b0;
    nxt_pcwr.target = pcwr_ff.target;
    nxt_flush     = 1'b0;
    nxt_done      = 1'b0;
    nxt_is_branch = 1'b0;
    case (state_ff)
      CFBX_ST_EXEC: begin
        if (cycle_end) begin
          nxt_is_branch = hit_ovf || hit_zero;
          if (taken) begin
            // Target is the incremented PC plus twice the offset.
            nxt_pcwr.load   = 1'b1;
            nxt_pcwr.target = pc_now + disp;
            nxt_flush       = 1'b1;
            nxt_state       = CFBX_ST_FLUSH;
          end else begin
            nxt_done = hit_ovf || hit_zero;
          end
        end
      end
      CFBX_ST_FLUSH: begin
        // The second cycle does nothing but discard the prefetched word.
        nxt_flush = 1'b1;
        if (cycle_end) begin
          nxt_flush = 1'b0;
          nxt_done  = 1'b1;
          nxt_state = CFBX_ST_EXEC;
        end
      end
      default: begin
        nxt_state = CFBX_ST_EXEC;
      end
    endcase
  end

  // Registers.
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      state_ff      <= CFBX_ST_EXEC;
      pcwr_ff       <= '{load: 1'b0, target: CFBX_PC_RST};
      flush_ff      <= 1'b0;
      instr_done_ff <= 1'b0;
      is_branch_ff  <= 1'b0;
    end else begin
      state_ff      <= nxt_state;
      pcwr_ff       <= nxt_pcwr;
      flush_ff      <= nxt_flush;
      instr_done_ff <= nxt_done;
      is_branch_ff  <= nxt_is_branch;
    end
  end

endmodule : cfbx_branch_exec

`default_nettype wire

// ==== verification/cfbx_chk.sv ====
`timescale 1ns/1ps
`default_nettype none

module cfbx_chk (
  // Clock and reset.
  input wire logic                     core_clk,
  input wire logic                     rstn,
  // Watched ports.
  input wire cfbx_pkg::cfbx_instr_type instr,
  input wire logic [20:0]              pc_now,
  input wire cfbx_pkg::cfbx_flags_type flags,
  input wire cfbx_pkg::cfbx_pcwr_type  pcwr_ff,
  input wire logic                     flush_ff,
  input wire logic                     instr_done_ff,
  input wire logic                     is_branch_ff
);
  import cfbx_pkg::*;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rstn);
  // The opcode and offset stay put across the cycle, so one edge back still shows them.
  a_ovf_taken: assert property (is_branch_ff && $past(instr.word[15:8]) == CFBX_OPC_OVF |-> pcwr_ff.load == $past(flags.ovf)) else $error("overflow branch decision");
  a_zero_taken: assert property (is_branch_ff && $past(instr.word[15:8]) == CFBX_OPC_ZERO |-> pcwr_ff.load == $past(flags.zero)) else $error("zero branch decision");
  a_target_sum: assert property (pcwr_ff.load |-> pcwr_ff.target == $past(pc_now) + {{12{$past(instr.word[7])}}, $past(instr.word[7:0]), 1'b0}) else $error("branch target");
  a_untaken_one: assert property (is_branch_ff && !pcwr_ff.load |-> instr_done_ff && !flush_ff) else $error("untaken branch not one cycle");
  a_flush_cycle: assert property (pcwr_ff.load |-> flush_ff && is_branch_ff ##1 flush_ff[*3] ##[1:2] (instr_done_ff && !flush_ff)) else $error("taken branch flush cycle");
  a_load_pulse: assert property (pcwr_ff.load |=> !pcwr_ff.load) else $error("load longer than one clock");
  // Main scenarios.
  c_taken: cover property (pcwr_ff.load);
  c_untaken: cover property (is_branch_ff && !pcwr_ff.load);
  c_back_ofs: cover property (pcwr_ff.load && $past(instr.word[7]));
endmodule : cfbx_chk

bind cfbx_branch_exec cfbx_chk u_chk (.core_clk(core_clk), .rstn(rstn), .instr(instr), .pc_now(pc_now), .flags(flags), .pcwr_ff(pcwr_ff), .flush_ff(flush_ff), .instr_done_ff(instr_done_ff), .is_branch_ff(is_branch_ff));

`default_nettype wire

// ==== verification/conditional_flag_branch_exec_tb_top.sv ====
`timescale 1ns/1ps
`default_nettype none

module conditional_flag_branch_exec_tb_top;
  import cfbx_pkg::*;
  logic           core_clk = 1'b0;
  logic           rstn = 1'b0;
  cfbx_instr_type instr = '0;
  logic [20:0]    pc_now = '0;
  cfbx_flags_type flags = '0;
  cfbx_pcwr_type  pcwr_ff;
  logic           flush_ff;
  logic           instr_done_ff;
  logic           is_branch_ff;
  int             n_fail = 0;
  int             cmp_count = 0;
  int             seed = 82143;
  int             cyc = 0;
  int             k;
  // Device under test.
  cfbx_branch_exec DUT (.core_clk(core_clk), .rstn(rstn), .instr(instr), .pc_now(pc_now), .flags(flags), .pcwr_ff(pcwr_ff), .flush_ff(flush_ff), .instr_done_ff(instr_done_ff), .is_branch_ff(is_branch_ff));
  // Clock of 20 ns.
  always #10 core_clk = ~core_clk;
  // Counts cycles so that a hang ends the run.
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_fail++;
      results();
    end
  end
  // Bit compare.
  task automatic chk(input logic got, input logic exp, input string what);
    cmp_count++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch at %0t: %s", $time, what);
    end
  endtask : chk
  // Target compare.
  task automatic chk_pc(input logic [20:0] got, input logic [20:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch at %0t: target %h not %h", $time, got, exp);
    end
  endtask : chk_pc
  // Expected target: incremented PC plus the doubled signed offset.
  function automatic logic [20:0] tgt(input logic [20:0] p, input logic [7:0] n);
    return p + {{12{n[7]}}, n, 1'b0};
  endfunction : tgt
  // Presents one word and follows it to its end.
  task automatic run(input logic [15:0] w, input logic [1:0] f, input logic [20:0] p);
    logic br;
    logic tk;
    br = (w[15:8] === CFBX_OPC_OVF) || (w[15:8] === CFBX_OPC_ZERO);
    tk = (w[15:8] === CFBX_OPC_OVF) ? f[1] : (w[15:8] === CFBX_OPC_ZERO) && f[0];
    @(negedge core_clk);
    instr = {1'b1, w};
    flags = f;
    pc_now = p;
    for (int i = 0; i < 12 && is_branch_ff !== 1'b1; i++) @(negedge core_clk);
    chk(is_branch_ff, br, "decode");
    chk(pcwr_ff.load, tk, "taken");
    if (tk) chk_pc(pcwr_ff.target, tgt(p, w[7:0]));
    chk(instr_done_ff, br && !tk, "one cycle");
    instr.valid = 1'b0;
    if (tk) begin
      chk(flush_ff, 1'b1, "flush");
      for (int i = 0; i < 8 && instr_done_ff !== 1'b1; i++) @(negedge core_clk);
      chk(instr_done_ff, 1'b1, "two cycles");
      chk(flush_ff, 1'b0, "flush end");
    end
    $display("test %h flags %b done", w, f);
    repeat (4) @(negedge core_clk);
  endtask : run
  // Prints the counts and the verdict.
  task automatic results();
    $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : results
  // Corner offsets, untaken and non-branch words, reset in flush, then random words.
  initial begin
    repeat (8) @(negedge core_clk);
    rstn = 1'b1;
    run(16'he480, 2'b10, 21'h1fffff);
    run(16'he07f, 2'b01, 21'h000100);
    run(16'he455, 2'b01, 21'h000200);
    run(16'he055, 2'b10, 21'h000300);
    run(16'h1234, 2'b11, 21'h000400);
    // Reset in the middle of a taken branch must clear every output at once.
    @(negedge core_clk);
    instr = {1'b1, CFBX_OPC_ZERO, 8'h10};
    flags = 2'b01;
    for (int i = 0; i < 8 && flush_ff !== 1'b1; i++) @(negedge core_clk);
    chk(flush_ff, 1'b1, "flush before reset");
    instr.valid = 1'b0;
    rstn = 1'b0;
    @(negedge core_clk);
    chk(pcwr_ff.load || flush_ff || instr_done_ff || is_branch_ff, 1'b0, "reset clears");
    rstn = 1'b1;
    $display("test reset in flush done");
    repeat (60) begin
      k = $random(seed);
      run({k[1] ? k[31:24] : (k[0] ? CFBX_OPC_OVF : CFBX_OPC_ZERO), k[15:8]}, k[17:16], k[26:6]);
    end
    results();
  end
endmodule : conditional_flag_branch_exec_tb_top

`default_nettype wire
